// ### pbc_pkg.sv
package pbc_pkg;
    localparam int PORT_W = 8;
    localparam int MASK_W = 3;
    localparam int PB_SS   = 0;
    localparam int PB_SCK  = 1;
    localparam int PB_MOSI = 2;
    localparam int PB_MISO = 3;
    localparam int PB_TMR2_CMP_A = 4;
    localparam int PB_TMR1_CMP_A = 5;
    localparam int PB_TMR1_CMP_B = 6;
    localparam int PB_TMR01_CMP  = 7;
    localparam int PC_TMR3_CLK   = 3;
    localparam int PC_TMR3_CMP_C = 4;
    localparam int PC_TMR3_CMP_B = 5;
    localparam int PC_TMR3_CMP_A = 6;
    localparam int PC_TMR3_CAP   = 7;
    // Per-pin high-address mask thresholds, port C bit 0 in the lowest slot.
    localparam logic [MASK_W-1:0] PC_THRESH [PORT_W] = '{
        3'h7, 3'h7, 3'h6, 3'h5, 3'h4, 3'h3, 3'h2, 3'h1
    };
endpackage : pbc_pkg

// ### pbc_override.sv
`timescale 1ns/100ps
module pbc_override
    import pbc_pkg::*;
(
    // Clock and reset
    input  wire logic              clk,
    input  wire logic              rst_b,
    // Port B registers and pins
    input  wire logic [PORT_W-1:0] portb_dir,
    input  wire logic [PORT_W-1:0] portb_out,
    input  wire logic [PORT_W-1:0] portb_pin_in,
    output logic      [PORT_W-1:0] portb_pin_out,
    output logic      [PORT_W-1:0] portb_pin_oe,
    output logic      [PORT_W-1:0] portb_pullup,
    // Port C registers and pins
    input  wire logic [PORT_W-1:0] portc_dir,
    input  wire logic [PORT_W-1:0] portc_out,
    input  wire logic [PORT_W-1:0] portc_pin_in,
    output logic      [PORT_W-1:0] portc_pin_out,
    output logic      [PORT_W-1:0] portc_pin_oe,
    output logic      [PORT_W-1:0] portc_pullup,
    // Global controls
    input  wire logic              global_pullup_disable,
    input  wire logic              pin_change_group_enable,
    // Timer compare outputs and enables
    input  wire logic              timer0_compare_a_out,
    input  wire logic              timer1_compare_a_out,
    input  wire logic              timer1_compare_b_out,
    input  wire logic              timer1_compare_c_out,
    input  wire logic              timer2_compare_a_out,
    input  wire logic              timer3_compare_a_out,
    input  wire logic              timer3_compare_b_out,
    input  wire logic              timer3_compare_c_out,
    input  wire logic [PORT_W-1:0] compare_enable,
    // SPI
    input  wire logic              spi_enable_bit,
    input  wire logic              spi_master_select,
    input  wire logic              spi_master_out,
    input  wire logic              spi_slave_out,
    input  wire logic              spi_sck_out,
    output logic                   spi_master_in,
    output logic                   spi_slave_in,
    output logic                   spi_sck_in,
    output logic                   spi_slave_active,
    // Serial programming
    input  wire logic              prog_mode,
    input  wire logic              prog_data_out,
    output logic                   prog_data_in,
    // Pin change
    output logic [PORT_W-1:0]      pin_change_source,
    // External memory
    input  wire logic              ext_mem_enable,
    input  wire logic [MASK_W-1:0] ext_mem_high_addr_mask,
    input  wire logic [PORT_W-1:0] ext_mem_addr_high,
    // Timer 3 and clock output
    input  wire logic              divided_sysclk_en,
    input  wire logic              divided_sysclk_out,
    output logic                   timer3_capture_in,
    output logic                   timer3_clock_in
);

    // Synchroniser stages.
    logic [PORT_W-1:0] pb_s1_r;
    logic [PORT_W-1:0] pb_s2_r;
    logic [PORT_W-1:0] pc_s1_r;
    logic [PORT_W-1:0] pc_s2_r;
    logic [PORT_W-1:0] pb_s1_nxt;
    logic [PORT_W-1:0] pb_s2_nxt;
    logic [PORT_W-1:0] pc_s1_nxt;
    logic [PORT_W-1:0] pc_s2_nxt;
    // Port B pad controls.
    logic [PORT_W-1:0] pb_out_nxt;
    logic [PORT_W-1:0] pb_oe_nxt;
    logic [PORT_W-1:0] pb_pu_nxt;
    logic [PORT_W-1:0] pb_alt_val;
    // Port C pad controls.
    logic [PORT_W-1:0] pc_out_nxt;
    logic [PORT_W-1:0] pc_oe_nxt;
    logic [PORT_W-1:0] pc_pu_nxt;
    logic [PORT_W-1:0] pc_addr;
    // Values taken from the pins for the peripherals.
    logic [PORT_W-1:0] pin_change_nxt;
    logic              spi_master_in_nxt;
    logic              spi_slave_in_nxt;
    logic              spi_sck_in_nxt;
    logic              spi_slave_active_nxt;
    logic              prog_data_in_nxt;
    logic              capture_in_nxt;
    logic              clock_in_nxt;
    // SPI modes.
    logic              spi_m;
    logic              spi_s;

    // Pull-up of a pin left to its port registers.
    function automatic logic [PORT_W-1:0] reg_pullup(
        input logic [PORT_W-1:0] out_bits,
        input logic [PORT_W-1:0] dir_bits,
        input logic              disable_all
    );
        reg_pullup = out_bits & ~dir_bits & {PORT_W{~disable_all}};
    endfunction : reg_pullup

    // Pull-up of a pin that an alternate function forces to input.
    function automatic logic forced_pullup(
        input logic out_bit,
        input logic disable_all
    );
        forced_pullup = out_bit & ~disable_all;
    endfunction : forced_pullup

    // Which SPI pins the current mode forces to input.
    function automatic logic spi_forces_input(
        input int   pin,
        input logic master,
        input logic slave
    );
        if (pin == PB_MISO) begin
            spi_forces_input = master;
        end else begin
            spi_forces_input = slave;
        end
    endfunction : spi_forces_input

    // Port B synchroniser; only the second stage feeds logic.
    always_comb begin
        pb_s1_nxt = portb_pin_in;
        pb_s2_nxt = pb_s1_r;
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            pb_s1_r <= '0;
            pb_s2_r <= '0;
        end else begin
            pb_s1_r <= pb_s1_nxt;
            pb_s2_r <= pb_s2_nxt;
        end
    end

    // Port C synchroniser; only the second stage feeds logic.
    always_comb begin
        pc_s1_nxt = portc_pin_in;
        pc_s2_nxt = pc_s1_r;
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            pc_s1_r <= '0;
            pc_s2_r <= '0;
        end else begin
            pc_s1_r <= pc_s1_nxt;
            pc_s2_r <= pc_s2_nxt;
        end
    end

    assign spi_m = spi_enable_bit & spi_master_select;
    assign spi_s = spi_enable_bit & ~spi_master_select;

    // Port C pins used for addresses.
    for (genvar i = 0; i < PORT_W; i++) begin : g_addr
        assign pc_addr[i] = ext_mem_enable & (ext_mem_high_addr_mask < PC_THRESH[i]);
    end

    // Port B: register values, then compare, SPI and programming overrides.
    always_comb begin
        pb_alt_val                = portb_out;
        pb_alt_val[PB_TMR01_CMP]  = timer0_compare_a_out | timer1_compare_c_out;
        pb_alt_val[PB_TMR1_CMP_B] = timer1_compare_b_out;
        pb_alt_val[PB_TMR1_CMP_A] = timer1_compare_a_out;
        pb_alt_val[PB_TMR2_CMP_A] = timer2_compare_a_out;

        pb_out_nxt = portb_out;
        pb_oe_nxt  = portb_dir;
        pb_pu_nxt  = reg_pullup(portb_out, portb_dir, global_pullup_disable);

        for (int i = PB_TMR2_CMP_A; i < PORT_W; i++) begin
            if (compare_enable[i]) begin
                pb_out_nxt[i] = pb_alt_val[i];
            end
        end

        for (int i = PB_SS; i <= PB_MISO; i++) begin
            if (spi_forces_input(i, spi_m, spi_s)) begin
                pb_oe_nxt[i] = 1'b0;
                pb_pu_nxt[i] = forced_pullup(portb_out[i], global_pullup_disable);
            end
        end

        if (spi_m) begin
            pb_out_nxt[PB_MOSI] = spi_master_out;
            pb_out_nxt[PB_SCK]  = spi_sck_out;
        end
        if (spi_s) begin
            pb_out_nxt[PB_MISO] = spi_slave_out;
        end

        if (prog_mode) begin
            pb_out_nxt[PB_MISO] = prog_data_out;
            pb_oe_nxt[PB_MISO]  = 1'b1;
            pb_oe_nxt[PB_MOSI]  = 1'b0;
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            portb_pin_out <= '0;
            portb_pin_oe  <= '0;
            portb_pullup  <= '0;
        end else begin
            portb_pin_out <= pb_out_nxt;
            portb_pin_oe  <= pb_oe_nxt;
            portb_pullup  <= pb_pu_nxt;
        end
    end

    // Port C: register values, then timer 3 and clock output, then addresses.
    always_comb begin
        pc_out_nxt = portc_out;
        pc_oe_nxt  = portc_dir;
        pc_pu_nxt  = reg_pullup(portc_out, portc_dir, global_pullup_disable);

        if (divided_sysclk_en) begin
            pc_out_nxt[PC_TMR3_CAP] = divided_sysclk_out;
            pc_oe_nxt[PC_TMR3_CAP]  = 1'b1;
        end

        if (compare_enable[PC_TMR3_CMP_C]) begin
            pc_out_nxt[PC_TMR3_CMP_C] = timer3_compare_c_out;
        end

        if (compare_enable[PC_TMR3_CMP_B]) begin
            pc_out_nxt[PC_TMR3_CMP_B] = timer3_compare_b_out;
        end

        if (compare_enable[PC_TMR3_CMP_A]) begin
            pc_out_nxt[PC_TMR3_CMP_A] = timer3_compare_a_out;
        end

        for (int i = 0; i < PORT_W; i++) begin
            if (pc_addr[i]) begin
                pc_out_nxt[i] = ext_mem_addr_high[i];
                pc_oe_nxt[i]  = 1'b1;
                pc_pu_nxt[i]  = 1'b0;
            end
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            portc_pin_out <= '0;
            portc_pin_oe  <= '0;
            portc_pullup  <= '0;
        end else begin
            portc_pin_out <= pc_out_nxt;
            portc_pin_oe  <= pc_oe_nxt;
            portc_pullup  <= pc_pu_nxt;
        end
    end

    // Port B pin values handed to the peripherals.
    always_comb begin
        pin_change_nxt       = pb_s2_r & {PORT_W{pin_change_group_enable}};

        spi_master_in_nxt    = pb_s2_r[PB_MISO];
        spi_slave_in_nxt     = pb_s2_r[PB_MOSI];
        spi_sck_in_nxt       = pb_s2_r[PB_SCK];
        spi_slave_active_nxt = spi_s & ~pb_s2_r[PB_SS];

        prog_data_in_nxt     = pb_s2_r[PB_MOSI];
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            pin_change_source <= '0;
            spi_master_in     <= 1'b0;
            spi_slave_in      <= 1'b0;
            spi_sck_in        <= 1'b0;
            spi_slave_active  <= 1'b0;
            prog_data_in      <= 1'b0;
        end else begin
            pin_change_source <= pin_change_nxt;
            spi_master_in     <= spi_master_in_nxt;
            spi_slave_in      <= spi_slave_in_nxt;
            spi_sck_in        <= spi_sck_in_nxt;
            spi_slave_active  <= spi_slave_active_nxt;
            prog_data_in      <= prog_data_in_nxt;
        end
    end

    // Port C pin values handed to timer 3.
    always_comb begin
        capture_in_nxt = pc_s2_r[PC_TMR3_CAP];
        clock_in_nxt   = pc_s2_r[PC_TMR3_CLK];
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            timer3_capture_in <= 1'b0;
            timer3_clock_in   <= 1'b0;
        end else begin
            timer3_capture_in <= capture_in_nxt;
            timer3_clock_in   <= clock_in_nxt;
        end
    end

endmodule : pbc_override

// ### pbc_override_properties.sv
`timescale 1ns/100ps
module pbc_override_properties
    import pbc_pkg::*;
(
    // Clock, reset, modes, timer 2 compare output and SPI slave active
    input wire logic              clk, rst_b, spi_enable_bit, spi_master_select, prog_mode,
    input wire logic              global_pullup_disable, pin_change_group_enable,
    input wire logic              timer2_compare_a_out, ext_mem_enable, spi_slave_active,
    // Buses
    input wire logic [PORT_W-1:0] portb_dir, portb_out, portb_pin_in, portb_pin_out,
    input wire logic [PORT_W-1:0] portb_pin_oe, portb_pullup, compare_enable,
    input wire logic [PORT_W-1:0] portc_dir, portc_pin_oe, portc_pin_out, portc_pullup,
    input wire logic [PORT_W-1:0] ext_mem_addr_high, pin_change_source,
    input wire logic [MASK_W-1:0] ext_mem_high_addr_mask
);
    logic mst, slv;
    assign mst = spi_enable_bit & spi_master_select & ~prog_mode;
    assign slv = spi_enable_bit & ~spi_master_select & ~prog_mode;
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_b);
    AST_MISO_IN: assert property (mst |=> !portb_pin_oe[PB_MISO])
        else $error("MISO driven as master");
    AST_MOSI_IN: assert property (slv |=> !portb_pin_oe[PB_MOSI])
        else $error("MOSI driven as slave");
    AST_SS_IN: assert property (slv |=> !portb_pin_oe[PB_SS] && !portb_pin_oe[PB_SCK])
        else $error("SS or SCK driven as slave");
    AST_SS_MST: assert property (mst |=> portb_pin_oe[PB_SS] == $past(portb_dir[PB_SS])
        && portb_pin_out[PB_SS] == $past(portb_out[PB_SS])) else $error("SS overridden");
    AST_FORCED_PU: assert property (slv |=> portb_pullup[PB_SS] ==
        $past(portb_out[PB_SS] & ~global_pullup_disable)) else $error("SS pull-up wrong");
    AST_CMP_B4: assert property (compare_enable[PB_TMR2_CMP_A] |=>
        portb_pin_out[PB_TMR2_CMP_A] == $past(timer2_compare_a_out)
        && portb_pin_oe[PB_TMR2_CMP_A] == $past(portb_dir[PB_TMR2_CMP_A]))
        else $error("B4 compare wrong");
    AST_ADDR_ALL: assert property (ext_mem_enable && ext_mem_high_addr_mask == 3'h0 |=>
        portc_pin_oe == 8'hFF && portc_pullup == 8'h00
        && portc_pin_out == $past(ext_mem_addr_high)) else $error("address pins wrong");
    AST_ADDR_NONE: assert property (ext_mem_enable && ext_mem_high_addr_mask == 3'h7 |=>
        portc_pin_oe[3:0] == $past(portc_dir[3:0])) else $error("low pins overridden");
    AST_PIN_CHANGE_SOURCE_OFF: assert property (!pin_change_group_enable [*3] |=>
        pin_change_source == 8'h00) else $error("pin change not gated");
    AST_SLAVE_SEL: assert property ((slv && !portb_pin_in[PB_SS]) [*4] |=>
        spi_slave_active) else $error("slave not active");
    COV_SLAVE: cover property (spi_slave_active);
    COV_ADDR: cover property (ext_mem_enable && portc_pin_oe == 8'hFF);
    COV_CMP: cover property (compare_enable[PB_TMR2_CMP_A] && portb_pin_oe[PB_TMR2_CMP_A]);
endmodule : pbc_override_properties

// ### pbc_pin_env.sv
`timescale 1ns/100ps
module pbc_pin_env (
    // Pad side of one port and the outside drivers
    input  wire logic [7:0] oe, out, pu, ext,
    output logic      [7:0] lvl
);
    // A driven pad shows its value, an undriven one its pull-up or the outside level.
    always_comb for (int i = 0; i < 8; i++) lvl[i] = oe[i] ? out[i] : (pu[i] | ext[i]);
endmodule : pbc_pin_env

// ### pbc_override_tb_top.sv
`timescale 1ns/100ps
module pbc_override_tb_top;
    import pbc_pkg::*;
    logic clk = 0, rst_b = 0, global_pullup_disable = 0, pin_change_group_enable = 0;
    logic timer0_compare_a_out = 0, timer1_compare_a_out = 0, timer1_compare_b_out = 0;
    logic timer1_compare_c_out = 0, timer2_compare_a_out = 0, timer3_compare_a_out = 0;
    logic timer3_compare_b_out = 0, timer3_compare_c_out = 0, spi_enable_bit = 0;
    logic spi_master_select = 0, spi_master_out = 0, spi_slave_out = 0, spi_sck_out = 0;
    logic prog_mode = 0, prog_data_out = 0, ext_mem_enable = 0, divided_sysclk_en = 0;
    logic divided_sysclk_out = 0, spi_master_in, spi_slave_in, spi_sck_in, spi_slave_active;
    logic prog_data_in, timer3_capture_in, timer3_clock_in;
    logic [7:0] portb_dir = '0, portb_out = '0, portc_dir = '0, portc_out = '0, e;
    logic [7:0] compare_enable = '0, ext_mem_addr_high = '0, ext_b = '0, ext_c = '0;
    logic [7:0] portb_pin_in, portb_pin_out, portb_pin_oe, portb_pullup, pin_change_source;
    logic [7:0] portc_pin_in, portc_pin_out, portc_pin_oe, portc_pullup;
    logic [2:0] ext_mem_high_addr_mask = '0;
    int errors = 0, n_tests = 0;
    pbc_override pbc_override_inst (.*);
    pbc_pin_env pbc_pin_env_inst (.oe(portb_pin_oe), .out(portb_pin_out), .pu(portb_pullup),
        .ext(ext_b), .lvl(portb_pin_in));
    pbc_pin_env pbc_pin_env_c_inst (.oe(portc_pin_oe), .out(portc_pin_out), .pu(portc_pullup),
        .ext(ext_c), .lvl(portc_pin_in));
    initial forever #4 clk = ~clk;
    task automatic chk(string nm, logic [7:0] ex, logic [7:0] got);
        n_tests++;
        if (got !== ex) begin
            errors++;
            $display("wrong value %s expected %h seen %h", nm, ex, got);
        end
    endtask : chk
    task automatic cyc(int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : cyc
    task automatic results;
        $display("errors %0d n_tests %0d", errors, n_tests);
        if (errors == 0 && n_tests > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask : results
    initial begin
        cyc(20);
        chk("reset oe", 8'h00, portb_pin_oe);
        rst_b = 1;
        compare_enable = 8'hF0;
        portb_dir = 8'h10;
        {timer0_compare_a_out, timer1_compare_b_out, timer2_compare_a_out} = 3'h7;
        cyc(2);
        chk("pb compare", 8'hD0, portb_pin_out & 8'hF0);
        chk("pb oe", 8'h10, portb_pin_oe);
        $display("test compare done");
        {compare_enable, spi_enable_bit, spi_master_select} = {8'h00, 2'h3};
        {portb_dir, portb_out, spi_master_out, spi_sck_out} = {8'h0F, 8'h08, 2'h3};
        cyc(5);
        chk("master oe", 8'h07, portb_pin_oe);
        chk("master out", 8'h06, portb_pin_out & 8'h07);
        chk("master pullup", 8'h08, portb_pullup);
        chk("master in", 8'h01, spi_master_in);
        $display("test master done");
        {spi_master_select, portb_out, spi_slave_out} = {1'b0, 8'h00, 1'b1};
        ext_b = 8'h06;
        cyc(5);
        chk("slave oe", 8'h08, portb_pin_oe);
        chk("slave out", 8'h08, portb_pin_out & 8'h0F);
        chk("slave in", 8'h07, {spi_slave_in, spi_sck_in, spi_slave_active});
        $display("test slave done");
        {prog_mode, prog_data_out, portb_dir} = {2'h3, 8'h08};
        cyc(5);
        chk("prog out", 8'h03, {portb_pin_out[3], portb_pin_oe[3]});
        chk("prog in", 8'h01, prog_data_in);
        {prog_mode, spi_enable_bit, portb_dir, pin_change_group_enable} = 11'h001;
        ext_b = 8'hA5;
        cyc(5);
        chk("pin change", 8'hA5, pin_change_source);
        pin_change_group_enable = 0;
        cyc(5);
        chk("pin change off", 8'h00, pin_change_source);
        $display("test prog and pin change done");
        {ext_mem_enable, ext_mem_addr_high, portc_out} = {1'b1, 8'h5A, 8'hFF};
        for (int m = 0; m < 8; m++) begin
            ext_mem_high_addr_mask = m[2:0];
            for (int i = 0; i < 8; i++) e[i] = (m < ((i > 1) ? 8 - i : 7));
            cyc(2);
            chk("pc oe", e, portc_pin_oe);
            chk("pc out", (e & 8'h5A) | ~e, portc_pin_out);
            chk("pc pullup", ~e, portc_pullup);
        end
        $display("test address done");
        {ext_mem_enable, portc_out, compare_enable, ext_c} = {1'b0, 8'h00, 8'h70, 8'h88};
        {timer3_compare_a_out, timer3_compare_b_out, timer3_compare_c_out} = 3'h5;
        {divided_sysclk_en, divided_sysclk_out} = 2'h3;
        cyc(5);
        chk("pc timer3", 8'hD0, portc_pin_out & 8'hF0);
        chk("timer3 in", 8'h03, {timer3_capture_in, timer3_clock_in});
        $display("test timer3 done");
        results();
    end
endmodule : pbc_override_tb_top
bind pbc_override pbc_override_properties pbc_override_properties_inst (.*);
